//--- verilog/asar_core.sv
// slot arbiter, sampling sequencer, result store and interrupt pulses
// assumes synchronous trigger pulses and sample data from an external mux
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps

// Summary of operation
// R1: one pending flag per slot, set by trigger, cleared at conversion end
// R2: pointer names last granted slot, updated at every completion
// R3: pointer reads slot 15 after reset so slot 0 goes first
// R4: search pending from pointer plus one upward, wrapping after 15
// R5: sample for the whole window, convert only after it ends
// R6: two hold paths; single uses one, simultaneous captures both together
// R7: simultaneous pair converts the upper path value first
// R8: one bit per even/odd pair picks single or simultaneous
// R9: window and channel always come from the triggered slot
// R10: each result goes to its slot's own result register and output
// R11: end-of-conversion pulse, one converter period, before result latch
// R12: interrupt pulse one converter period after it, with the latch
// R13: nine interrupt outputs, each configured on its own
// R14: enable bit per interrupt; zero suppresses it
// R15: source select 00h-0Fh picks slot event; above is invalid
// R16: tenth interrupt fields are stored but do nothing
// R17: two-bit retrigger field per slot: none, irq 1, irq 2, invalid
// R18: non-zero retrigger field replaces the slot's timer trigger
// R19: conversion is window setting plus one, then 13 converter clocks
// R20: converter clock is system clock over 1, 2 or 4
// R21: software keeps window settings at 06h or more
// R22: trigger codes 05h-14h map to timer inputs; others flag error
// R23: repeated trigger on a pending slot gives one conversion
// R24: arbitrate only when ready for a new window, on current flags
module asar_core
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [asar_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [asar_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [asar_pkg::SLOTS-1:0] timer_trig,
   input wire logic [asar_pkg::RES_W-1:0] sample_a_data,
   input wire logic [asar_pkg::RES_W-1:0] sample_b_data,
   output logic [3:0] input_channel_code,
   output logic sample_a_en,
   output logic sample_b_en,
   output logic [asar_pkg::SLOTS-1:0] eoc_out,
   output logic [asar_pkg::NIRQ-1:0] converter_irq_out,
   output logic [asar_pkg::SLOTS-1:0][asar_pkg::RES_W-1:0] result_out
);
   import asar_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0] ctrl_q;
   logic [7:0] pair_q;
   logic [IRQ_CFG_REGS-1:0][31:0] irq_cfg_q;
   logic [31:0] map_q;
   logic [SLOTS-1:0][31:0] slot_cfg_q;
   asar_state_e state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [3:0] cur_q;
   logic [3:0] conv_slot_q;
   logic [3:0] last_granted_pointer_q;
   logic [RES_W-1:0] conv_val_q;
   logic [RES_W-1:0] hold_a_q;
   logic simul_q;
   logic second_q;
   logic [SLOTS-1:0] pend_q;
   logic [SLOTS-1:0] set_vec;
   logic [SLOTS-1:0] trig_err;
   logic [NIRQ-1:0] irq_new;
   logic [4:0] pick;
   logic tick;
   logic grant_go;
   logic latch_go;
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_data;
   logic rd_err;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // round robin: nearest pending slot after the pointer, {found, slot}
   function automatic logic [4:0] rr_pick(input logic [15:0] pend,
                                          input logic [3:0] ptr);
      logic [4:0] r;
      logic [3:0] k;
      r = 5'h00;
      for (int i = 16; i >= 1; i--)
      begin
         k = ptr + 4'(i);
         if (pend[k])
            r = {1'b1, k};
      end
      return r;
   endfunction

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[b*8 +: 8] = din[b*8 +: 8];
      return r;
   endfunction

   // enable and select of interrupt n, two interrupts per register
   function automatic logic [5:0] irq_field(input int n,
      input logic [IRQ_CFG_REGS-1:0][31:0] cfg);
      return cfg[n/2][(n%2)*IRQ_HALF +: 6];
   endfunction

   // ----------------------------------------------------------------
   // converter time base
   // ----------------------------------------------------------------
   // R20: divide select
   asar_clk_div u_div
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .halve_clock_enable(ctrl_q[0]),
      .quarter_clock_enable(ctrl_q[1]),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // trigger decode and pending flags
   // ----------------------------------------------------------------
   // R24: grant only when idle at a converter tick
   assign pick = rr_pick(pend_q, last_granted_pointer_q);
   assign grant_go = tick && (state_q == ST_IDLE) && pick[4];
   assign latch_go = tick && (state_q == ST_EOC);

   // R15: selects above 0Fh never match a 4-bit slot number
   always_comb
   begin
      logic [5:0] f;
      f = 6'h00;
      for (int n = 0; n < NIRQ; n++)
      begin
         f = irq_field(n, irq_cfg_q);
         irq_new[n] = latch_go && f[IRQ_EN_BIT] &&
                      (f[4:0] == {1'b0, conv_slot_q});
      end
   end

   // R17: retrigger field chooses trigger source per slot
   always_comb
   begin
      logic [1:0] m;
      logic [4:0] code;
      m = 2'b00;
      code = 5'h00;
      for (int s = 0; s < SLOTS; s++)
      begin
         m = map_q[s*2 +: 2];
         code = slot_cfg_q[s][CFG_TRIG_LSB +: 5];
         // R22: only codes in range reach a timer input
         trig_err[s] = (code < TRIG_LO) || (code > TRIG_HI);
         set_vec[s] = 1'b0;
         // R18: non-zero field overrides the timer trigger
         if (m == MAP_NONE && !trig_err[s])
            set_vec[s] = timer_trig[4'(code - TRIG_LO)];
         else if (m == MAP_IRQ1)
            set_vec[s] = irq_new[0];
         else if (m == MAP_IRQ2)
            set_vec[s] = irq_new[1];
      end
   end

   // R1: set beats the clear in the same cycle
   // R23: a set flag simply stays set
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pend_q <= 16'h0000;
      else if (latch_go && !second_q)
         pend_q <= (pend_q & ~(16'h0001 << cur_q)) | set_vec;
      else
         pend_q <= pend_q | set_vec;
   end

   // R2: pointer follows every completed conversion
   // R3: reset value points at slot 15
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         last_granted_pointer_q <= RR_RESET;
      else if (latch_go)
         last_granted_pointer_q <= cur_q;
   end

   // ----------------------------------------------------------------
   // sampling and conversion sequencer
   // ----------------------------------------------------------------
   // all moves happen on converter ticks only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 10'h000;
         cur_q <= 4'h0;
         conv_slot_q <= 4'h0;
         conv_val_q <= 12'h000;
         hold_a_q <= 12'h000;
         simul_q <= 1'b0;
         second_q <= 1'b0;
         input_channel_code <= 4'h0;
         sample_a_en <= 1'b0;
         sample_b_en <= 1'b0;
      end
      else if (tick)
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (pick[4])
               begin
                  // R4: first pending slot after the pointer
                  cur_q <= pick[3:0];
                  // R8: pair bit fixes the sampling mode
                  simul_q <= pair_q[pick[3:1]];
                  // R9: R19: window from the triggered slot, plus one
                  cnt_q <= {1'b0, slot_cfg_q[pick[3:0]][WIN_W-1:0]} +
                           10'h001;
                  input_channel_code <=
                     slot_cfg_q[pick[3:0]][CFG_CH_LSB +: 4];
                  // R6: both paths only in simultaneous mode
                  sample_a_en <= pair_q[pick[3:1]] ||
                                 !slot_cfg_q[pick[3:0]][CFG_CH_LSB + 3];
                  sample_b_en <= pair_q[pick[3:1]] ||
                                 slot_cfg_q[pick[3:0]][CFG_CH_LSB + 3];
                  state_q <= ST_SAMPLE;
               end
            end
            ST_SAMPLE:
            begin
               // R5: capture only at the end of the window
               if (cnt_q == 10'h001)
               begin
                  sample_a_en <= 1'b0;
                  sample_b_en <= 1'b0;
                  hold_a_q <= sample_a_data;
                  cnt_q <= CONV_CLKS - 10'h001;
                  state_q <= ST_CONV;
                  // R7: upper path first, its result to the odd slot
                  if (simul_q)
                  begin
                     conv_slot_q <= {cur_q[3:1], 1'b1};
                     conv_val_q <= sample_b_data;
                     second_q <= 1'b1;
                  end
                  else
                  begin
                     conv_slot_q <= cur_q;
                     conv_val_q <= input_channel_code[3] ?
                                   sample_b_data : sample_a_data;
                     second_q <= 1'b0;
                  end
               end
               else
                  cnt_q <= cnt_q - 10'h001;
            end
            ST_CONV:
            begin
               // R19: last of the 13 periods is spent in ST_EOC
               if (cnt_q == 10'h001)
                  state_q <= ST_EOC;
               else
                  cnt_q <= cnt_q - 10'h001;
            end
            ST_EOC:
            begin
               if (second_q)
               begin
                  conv_slot_q <= {cur_q[3:1], 1'b0};
                  conv_val_q <= hold_a_q;
                  second_q <= 1'b0;
                  cnt_q <= CONV_CLKS - 10'h001;
                  state_q <= ST_CONV;
               end
               else
                  state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // end-of-conversion, interrupts and results
   // ----------------------------------------------------------------
   // R11: R12: eoc for one period, then irq with the latch
   // R13: R14: R16: only nine outputs exist, tenth fields unread
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         eoc_out <= 16'h0000;
         converter_irq_out <= 9'h000;
      end
      else if (tick)
      begin
         eoc_out <= (state_q == ST_CONV && cnt_q == 10'h001) ?
                    (16'h0001 << conv_slot_q) : 16'h0000;
         converter_irq_out <= irq_new;
      end
   end

   // R10: result lands in its own slot
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         result_out <= '0;
      else if (latch_go)
         result_out[conv_slot_q] <= conv_val_q;
   end

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   // both write channels must be present; one access at a time
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                  !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

   // configuration writes; R21 left to software
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= 2'b00;
         pair_q <= 8'h00;
         irq_cfg_q <= '0;
         map_q <= 32'h0000_0000;
         slot_cfg_q <= '0;
      end
      else if (wr_go && s_axi_awaddr[1:0] == 2'b00)
      begin
         if (s_axi_awaddr == OFS_CTRL)
            ctrl_q <= 2'(wmerge({30'h0, ctrl_q}, s_axi_wdata, s_axi_wstrb));
         else if (s_axi_awaddr == OFS_PAIR)
            pair_q <= 8'(wmerge({24'h0, pair_q}, s_axi_wdata, s_axi_wstrb));
         else if (s_axi_awaddr >= OFS_IRQ_CFG &&
                  s_axi_awaddr < OFS_MAP_LO)
            irq_cfg_q[3'(s_axi_awaddr[4:2] - 3'h2)] <=
               wmerge(irq_cfg_q[3'(s_axi_awaddr[4:2] - 3'h2)],
                      s_axi_wdata, s_axi_wstrb) & IRQ_CFG_MASK;
         else if (s_axi_awaddr == OFS_MAP_LO)
            map_q[15:0] <= 16'(wmerge({16'h0, map_q[15:0]}, s_axi_wdata,
                                      s_axi_wstrb));
         else if (s_axi_awaddr == OFS_MAP_HI)
            map_q[31:16] <= 16'(wmerge({16'h0, map_q[31:16]}, s_axi_wdata,
                                       s_axi_wstrb));
         else if (s_axi_awaddr >= OFS_SLOT_CFG &&
                  s_axi_awaddr < OFS_RESULT)
            slot_cfg_q[s_axi_awaddr[5:2]] <=
               wmerge(slot_cfg_q[s_axi_awaddr[5:2]], s_axi_wdata,
                      s_axi_wstrb) & SLOT_CFG_MASK;
      end
   end

   // write handshake and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
      end
      else
      begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr[1:0] != 2'b00 ||
                            s_axi_awaddr == OFS_STATUS ||
                            (s_axi_awaddr > OFS_STATUS &&
                             s_axi_awaddr < OFS_SLOT_CFG) ||
                            s_axi_awaddr >= OFS_RESULT) ?
                           RESP_SLVERR : RESP_OK;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read decode; unmapped answers with an error and zero data
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (s_axi_araddr[1:0] != 2'b00)
         rd_err = 1'b1;
      else if (s_axi_araddr == OFS_CTRL)
         rd_data = {30'h0, ctrl_q};
      else if (s_axi_araddr == OFS_PAIR)
         rd_data = {24'h0, pair_q};
      else if (s_axi_araddr >= OFS_IRQ_CFG && s_axi_araddr < OFS_MAP_LO)
         rd_data = irq_cfg_q[3'(s_axi_araddr[4:2] - 3'h2)];
      else if (s_axi_araddr == OFS_MAP_LO)
         rd_data = {16'h0, map_q[15:0]};
      else if (s_axi_araddr == OFS_MAP_HI)
         rd_data = {16'h0, map_q[31:16]};
      else if (s_axi_araddr == OFS_STATUS)
         rd_data = {8'h0, state_q, last_granted_pointer_q, pend_q};
      else if (s_axi_araddr == OFS_STATUS + 8'h04)
         rd_data = {16'h0, trig_err};
      else if (s_axi_araddr >= OFS_SLOT_CFG && s_axi_araddr < OFS_RESULT)
         rd_data = slot_cfg_q[s_axi_araddr[5:2]];
      else if (s_axi_araddr >= OFS_RESULT && s_axi_araddr < 8'hC0)
         rd_data = {20'h0, result_out[s_axi_araddr[5:2]]};
      else
         rd_err = 1'b1;
   end

   // read handshake; data valid with the address accept
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OK;
      end
      else
      begin
         s_axi_arready <= rd_go;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OK;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_RR_RESET: assert property (@(posedge aclk) !aresetn |=> // R3
      last_granted_pointer_q == 4'hF) else $error("pointer not 15");
   AST_PEND_SET: assert property (@(posedge aclk) // R1
      disable iff (!aresetn) (|set_vec) |=>
      ((pend_q & $past(set_vec)) == $past(set_vec)))
      else $error("trigger lost");
   AST_PEND_CLR: assert property (@(posedge aclk) // R1
      disable iff (!aresetn) latch_go && !second_q && !set_vec[cur_q]
      |=> pend_q[$past(cur_q)] == 1'b0) else $error("flag not cleared");
   AST_PTR_UPD: assert property (@(posedge aclk) // R2
      disable iff (!aresetn) latch_go |=>
      last_granted_pointer_q == $past(cur_q)) else $error("pointer stale");
   AST_RR_ORDER: assert property (@(posedge aclk) // R4
      disable iff (!aresetn) grant_go |-> pend_q[pick[3:0]] &&
      (pick[3:0] == last_granted_pointer_q + 4'h1 ||
       !pend_q[last_granted_pointer_q + 4'h1]))
      else $error("round robin order broken");
   AST_NO_SAMPLE_IN_CONV: assert property (@(posedge aclk) // R5
      disable iff (!aresetn) state_q == ST_CONV |->
      !sample_a_en && !sample_b_en) else $error("sampling in conversion");
   AST_DUAL_ONLY_SIMUL: assert property (@(posedge aclk) // R6
      disable iff (!aresetn) sample_a_en && sample_b_en |-> simul_q)
      else $error("both paths in single mode");
   AST_UPPER_FIRST: assert property (@(posedge aclk) // R7
      disable iff (!aresetn) tick && state_q == ST_SAMPLE &&
      cnt_q == 10'h001 && simul_q |=> conv_slot_q[0] && second_q)
      else $error("lower path converted first");
   AST_EOC_ONEHOT: assert property (@(posedge aclk) // R11
      disable iff (!aresetn) $rose(|eoc_out) |->
      $countones(eoc_out) == 1 && state_q == ST_EOC)
      else $error("eoc malformed");
   AST_IRQ_AFTER_EOC: assert property (@(posedge aclk) // R12
      disable iff (!aresetn) latch_go |=> eoc_out == 16'h0000 &&
      converter_irq_out == $past(irq_new)) else $error("irq timing");
endmodule

//--- verilog/asar_pkg.sv
// constants for the converter slot arbiter and its interrupt outputs
// assumes one 25 MHz system clock and an AXI4-Lite register master
package asar_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int SLOTS = 16;
   localparam int NIRQ = 9;
   localparam int RES_W = 12;
   localparam int ADDR_W = 8;
   localparam int WIN_W = 9;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] CONV_CLKS = 10'h00D;
   localparam logic [3:0] RR_RESET = 4'hF;
   localparam logic [4:0] TRIG_LO = 5'h05;
   localparam logic [4:0] TRIG_HI = 5'h14;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PAIR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CFG = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MAP_LO = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_MAP_HI = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_SLOT_CFG = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h80;
   localparam int IRQ_CFG_REGS = 5;
   // ----------------------------------------------------------------
   // field positions and masks
   // ----------------------------------------------------------------
   localparam int CFG_CH_LSB = 15;
   localparam int CFG_TRIG_LSB = 20;
   localparam int IRQ_EN_BIT = 5;
   localparam int IRQ_HALF = 8;
   localparam logic [31:0] SLOT_CFG_MASK = 32'h01F7_81FF;
   localparam logic [31:0] IRQ_CFG_MASK = 32'h0000_3F3F;
   localparam logic [1:0] MAP_NONE = 2'b00;
   localparam logic [1:0] MAP_IRQ1 = 2'b01;
   localparam logic [1:0] MAP_IRQ2 = 2'b10;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_CONV = 4'b0100,
      ST_EOC = 4'b1000
   } asar_state_e;
endpackage

//--- verilog/asar_clk_div.sv
// converter time base: one tick per converter clock period
// assumes divider bits are static while conversions run
`timescale 1ns/10ps
module asar_clk_div
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic halve_clock_enable,
   input wire logic quarter_clock_enable,
   output logic tick
);
   import asar_pkg::*;
   logic [1:0] cnt_q;
   logic [1:0] limit;

   // quarter bit alone leaves the clock undivided
   assign limit = !halve_clock_enable ? 2'h0 :
                  (quarter_clock_enable ? 2'h3 : 2'h1);

   // free counter, tick registered so it is glitch free
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= 2'h0;
         tick <= 1'b0;
      end
      else
      begin
         cnt_q <= (cnt_q >= limit) ? 2'h0 : cnt_q + 2'h1;
         tick <= (cnt_q >= limit);
      end
   end
endmodule

//--- tb/asar_partner.sv
// partner: timer trigger pulses and the two held-path sample sources
// assumes the bench requests each trigger for one cycle only
`timescale 1ns/10ps
module asar_partner
(
   input wire logic aclk,
   input wire logic [15:0] fire,
   input wire logic sample_a_en,
   input wire logic sample_b_en,
   output logic [15:0] timer_trig,
   output logic [11:0] sample_a_data,
   output logic [11:0] sample_b_data
);
   // trigger pulses follow the bench request by one edge
   always_ff @(posedge aclk)
   begin
      timer_trig <= fire;
   end
   // inverse level when not sampled, so a late capture shows
   assign sample_a_data = sample_a_en ? 12'hA5C : 12'h5A3;
   assign sample_b_data = sample_b_en ? 12'h3C6 : 12'hC39;
endmodule

//--- tb/tb.sv
// bench: register bus, round robin grants, results and interrupt pulses
// assumes asar_core behind AXI4-Lite and the partner on the trigger side
`timescale 1ns/10ps
module tb;
   import asar_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, sample_a_en, sample_b_en;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, input_channel_code;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] timer_trig, eoc_out, fire;
   logic [11:0] sample_a_data, sample_b_data;
   logic [8:0] converter_irq_out;
   logic [15:0][11:0] result_out;
   int fails = 0, total_checks = 0, cyc = 0, run = 0, win = 0;
   asar_core asar_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_trig,
      .sample_a_data, .sample_b_data, .input_channel_code, .sample_a_en,
      .sample_b_en, .eoc_out, .converter_irq_out, .result_out);
   asar_partner asar_partner_inst (.aclk, .fire, .sample_a_en, .sample_b_en,
      .timer_trig, .sample_a_data, .sample_b_data);
   // ----------------------------------------------------------------
   // clock, window monitor and hang limit (run is about 150 cycles)
   // ----------------------------------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (sample_a_en === 1'b1)
         run <= run + 1;
      else if (run != 0)
      begin
         win <= run;
         run <= 0;
      end
      if (cyc == 5000)
      begin
         fails++;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // bus and checking tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task wait_eoc;
      while (eoc_out !== 16'h0000)
         @(posedge aclk);
      do @(posedge aclk);
      while (eoc_out === 16'h0000);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset_and_bus;
      rd(OFS_STATUS);
      chk(d[19:0], 20'hF_0000);
      rd(8'h3C);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0000_0000);
      wr(OFS_RESULT, 32'h0000_0FFF, RESP_SLVERR);
   endtask
   task t_round_robin;
      wr(OFS_CTRL, 32'h0000_0000, RESP_OK);
      wr(OFS_SLOT_CFG, 32'h0050_0006, RESP_OK);
      wr(OFS_SLOT_CFG + 8'h0C, 32'h0082_8006, RESP_OK);
      wr(OFS_IRQ_CFG, 32'h0000_0023, RESP_OK);
      fire <= 16'h0009;
      @(posedge aclk);
      fire <= 16'h0000;
      wait_eoc();
      chk(eoc_out, 16'h0001);
      chk(win, 7);
      @(posedge aclk);
      chk(eoc_out, 16'h0000);
      chk(converter_irq_out, 9'h000);
      chk(result_out[0], 12'hA5C);
      wait_eoc();
      chk(eoc_out, 16'h0008);
      @(posedge aclk);
      chk(converter_irq_out, 9'h001);
      chk(result_out[3], 12'hA5C);
      chk(input_channel_code, 4'h5);
      rd(OFS_STATUS);
      chk(d[19:0], 20'h3_0000);
   endtask
   // halved clock, pair 0 simultaneous: odd slot first, window doubled
   task t_simultaneous;
      wr(OFS_CTRL, 32'h0000_0001, RESP_OK);
      wr(OFS_PAIR, 32'h0000_0001, RESP_OK);
      fire <= 16'h0001;
      @(posedge aclk);
      fire <= 16'h0000;
      wait_eoc();
      chk(eoc_out, 16'h0002);
      chk(win, 14);
      wait_eoc();
      chk(eoc_out, 16'h0001);
      chk(input_channel_code, 4'h0);
      chk(result_out[1], 12'h3C6);
      repeat (2) @(posedge aclk);
      chk(result_out[0], 12'hA5C);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // reset for two cycles, then the scenarios in order
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      fire = 16'h0000;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_and_bus();
      t_round_robin();
      t_simultaneous();
      conclude();
   end
endmodule
